// ---- bench/tb.sv ----
/*
 Testbench for the baud generator: APB register tests and tick spacing
 per mode. Assumes a 40 MHz clock and the engine model on the tick side.
*/
module tb
   import ubrg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, r;
   logic pready_o, pslverr_o, ovf, cko, per, p0, bit_t, sh, tflag, err;
   int miscompares = 0, n_tests = 0, p0n = 0, gap_o [3], cnt_o [4];
   // Mode table: control word, tick source, expected spacing
   int cfg [12] = '{'h003, 'h081, 'h083, 'h001, 'h041, 'h049, 'h04D, 'h045, 'h023, 'h067, 'h021, 'h021};
   int sel [12] = '{2, 2, 2, 2, 1, 1, 1, 1, 1, 1, 1, 0};
   int gap [12] = '{4, 12, 4, 12, 64, 192, 96, 32, 64, 32, 768, 48};
   always #12.5 clock_i = ~clock_i;
   ubrg_top uut (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .baud_overflow_pulse_o(ovf),
      .baud_clock_out_o(cko), .periph_toggle_o(per), .port0_time_base_o(p0),
      .bit_tick_o(bit_t), .shift_tick_o(sh), .timer_flag_o(tflag));
   ubrg_engine_model eng (.clock_i(clock_i), .rstn_i(rstn_i), .tick_i({sh, bit_t, ovf}),
      .evt_i({p0, per, cko, ovf}), .gap_o(gap_o), .cnt_o(cnt_o));
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // One APB transfer; waits for pready under a bound
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         miscompares++;
         final_report();
      end
      r = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0000_0000);
      chk(n, r, e);
   endtask
   initial begin
      repeat (16) @(posedge clock_i);
      rstn_i <= 1'b1;
      for (int i = 0; i < 4; i++) rd(8'(i * 4), 32'h0000_0000, "reset value");
      rd(8'h10, 32'h0000_0000, "unmapped");
      chk("pslverr", {31'h0, err}, 32'h1);
      xfer(1'b1, UBRG_OFS_RELOAD, 32'hA5);
      rd(UBRG_OFS_COUNTER, 32'hA5, "stopped counter");
      xfer(1'b1, UBRG_OFS_COUNTER, 32'h12);
      rd(UBRG_OFS_RELOAD, 32'hA5, "reload kept");
      rd(UBRG_OFS_COUNTER, 32'h12, "counter");
      xfer(1'b1, UBRG_OFS_RELOAD, 32'h00);
      xfer(1'b1, UBRG_OFS_CTRL, 32'h1);
      xfer(1'b1, UBRG_OFS_RELOAD, 32'h80);
      xfer(1'b0, UBRG_OFS_COUNTER, 32'h0);
      chk("running counter", {31'h0, r[7]}, 32'h0);
      xfer(1'b1, UBRG_OFS_CTRL, 32'h0E0);
      rd(UBRG_OFS_CTRL, 32'h0000_0000, "illegal mode");
      $display("test registers done");
      xfer(1'b1, UBRG_OFS_CTRL, 32'h0);
      xfer(1'b1, UBRG_OFS_RELOAD, 32'hFC);
      xfer(1'b1, UBRG_OFS_CTRL, 32'h13);
      repeat (100) @(posedge clock_i);
      @(negedge clock_i);
      chk("port 0 base", 32'(cnt_o[3]), 32'(cnt_o[0]));
      xfer(1'b1, UBRG_OFS_CTRL, 32'h103);
      // Let the last selected overflow reach the model, then no more may follow
      repeat (2) @(negedge clock_i);
      p0n = cnt_o[3];
      repeat (10) @(negedge clock_i);
      chk("port 0 off", 32'(cnt_o[3]), 32'(p0n));
      xfer(1'b0, UBRG_OFS_STATUS, 32'h0);
      chk("status", r & 32'h5, 32'h5);
      // Stop first, so that the clearing write cannot meet an overflow
      xfer(1'b1, UBRG_OFS_CTRL, 32'h100);
      repeat (3) @(negedge clock_i);
      chk("timer flag held", {31'h0, tflag}, 32'h1);
      xfer(1'b1, UBRG_OFS_CTRL, 32'h0);
      repeat (3) @(negedge clock_i);
      chk("timer flag", {31'h0, tflag}, 32'h0);
      $display("test timer done");
      for (int i = 0; i < 12; i++) begin
         xfer(1'b1, UBRG_OFS_CTRL, 32'(cfg[i]));
         repeat (3 * gap[i] + 20) @(posedge clock_i);
         @(negedge clock_i);
         chk("tick gap", 32'(gap_o[sel[i]]), 32'(gap[i]));
      end
      xfer(1'b1, UBRG_OFS_CTRL, 32'h0);
      repeat (60) @(negedge clock_i);
      chk("clock out", 32'(cnt_o[1]), 32'(cnt_o[0]));
      chk("peripheral", 32'(cnt_o[2]), 32'(cnt_o[0]));
      $display("test modes done");
      final_report();
   end
endmodule

// ---- bench/ubrg_assertions.sv ----
/*
 Port checker for the baud generator top. Assumes one clock domain and
 zero-wait APB reads latched at the setup edge.
*/
module ubrg_checker
   import ubrg_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic baud_overflow_pulse_o,
   input wire logic baud_clock_out_o,
   input wire logic periph_toggle_o,
   input wire logic port0_time_base_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic setup, mapped;
   // Setup phase and decoded address
   assign setup = psel_i && !penable_i;
   assign mapped = paddr_i inside {UBRG_OFS_CTRL, UBRG_OFS_RELOAD, UBRG_OFS_COUNTER, UBRG_OFS_STATUS};
   property p_ready; pready_o; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_bad; setup && !pwrite_i && !mapped |=> pslverr_o && prdata_o == UBRG_ZERO32; endproperty
   a_bad: assert property (p_bad) else $error("unmapped read not refused");
   property p_ok; setup && mapped |=> !pslverr_o; endproperty
   a_ok: assert property (p_ok) else $error("mapped access refused");
   property p_hold; !setup |=> $stable(prdata_o) && $stable(pslverr_o); endproperty
   a_hold: assert property (p_hold) else $error("read answer moved");
   property p_clk; $changed(baud_clock_out_o) |-> ##[0:1] (baud_overflow_pulse_o || $past(baud_overflow_pulse_o));
   endproperty
   a_clk: assert property (p_clk) else $error("clock out moved without overflow");
   property p_per; $changed(periph_toggle_o) |-> ##[0:1] (baud_overflow_pulse_o || $past(baud_overflow_pulse_o));
   endproperty
   a_per: assert property (p_per) else $error("toggle moved without overflow");
   property p_twin; baud_clock_out_o == periph_toggle_o; endproperty
   a_twin: assert property (p_twin) else $error("toggle outputs differ");
   property p_p0; port0_time_base_o |-> baud_overflow_pulse_o; endproperty
   a_p0: assert property (p_p0) else $error("port 0 base without overflow");
endmodule

bind ubrg_top ubrg_checker chk (.*);

// ---- bench/ubrg_engine_model.sv ----
/*
 Serial engine stand-in: measures tick spacing and counts overflow side
 outputs. Assumes ticks are one-cycle pulses on the system clock.
*/
module ubrg_engine_model
   import ubrg_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic [2:0] tick_i,
   input wire logic [3:0] evt_i,
   output int gap_o [3],
   output int cnt_o [4]
);
   timeunit 1ns;
   timeprecision 1ps;
   int since [3];
   logic co_q, pe_q;
   // Gap of each tick source, overflow count and toggle counts
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         since = '{0, 0, 0};
         gap_o = '{0, 0, 0};
         cnt_o = '{0, 0, 0, 0};
         co_q = 1'b0;
         pe_q = 1'b0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            since[i]++;
            if (tick_i[i] === 1'b1) begin
               gap_o[i] = since[i];
               since[i] = 0;
            end
         end
         if (evt_i[0] === 1'b1) cnt_o[0]++;
         if (evt_i[1] !== co_q) cnt_o[1]++;
         if (evt_i[2] !== pe_q) cnt_o[2]++;
         if (evt_i[3] === 1'b1) cnt_o[3]++;
         co_q = evt_i[1];
         pe_q = evt_i[2];
      end
   end
endmodule

// ---- src/ubrg_apb.sv ----
/*
 APB slave for the baud generator registers. Zero wait states; unmapped
 addresses read zero and raise pslverr. Assumes one clock with the core.
*/
module ubrg_apb
   import ubrg_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] rd_ctrl_i,
   input wire logic [31:0] rd_reload_i,
   input wire logic [31:0] rd_counter_i,
   input wire logic [31:0] rd_status_i,
   output logic wr_ctrl_o,
   output logic wr_reload_o,
   output logic wr_counter_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o
);
   typedef struct packed {
      logic [31:0] rdata;
      logic err;
   } ubrg_apb_s;
   ubrg_apb_s s_q, s_d;
   logic access;
   logic hit;
   logic [31:0] mux;

   // Setup phase and address decode
   always_comb begin
      access = psel_i && !penable_i;
      hit = 1'b1;
      unique case (paddr_i)
         UBRG_OFS_CTRL: mux = rd_ctrl_i;
         UBRG_OFS_RELOAD: mux = rd_reload_i;
         UBRG_OFS_COUNTER: mux = rd_counter_i;
         UBRG_OFS_STATUS: mux = rd_status_i;
         default: begin
            mux = UBRG_ZERO32;
            hit = 1'b0;
         end
      endcase
      s_d = s_q;
      if (access) begin
         s_d.rdata = pwrite_i ? UBRG_ZERO32 : mux;
         s_d.err = !hit;
      end
   end

   // Write strobes in the access phase
   always_comb begin
      wr_ctrl_o = psel_i && penable_i && pwrite_i && (paddr_i == UBRG_OFS_CTRL);
      wr_reload_o = psel_i && penable_i && pwrite_i && (paddr_i == UBRG_OFS_RELOAD);
      wr_counter_o = psel_i && penable_i && pwrite_i && (paddr_i == UBRG_OFS_COUNTER);
   end

   // Read data latched at setup, held through access
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_o = s_q.rdata;
   assign pslverr_o = s_q.err;
endmodule

// ---- src/ubrg_divider.sv ----
/*
 Programmable divider: emits a one-cycle pulse every (term+1) enabled ticks.
 Assumes term is stable or that a restart on change is acceptable.
*/
module ubrg_divider
   import ubrg_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic en_i,
   input wire logic [7:0] term_i,
   output logic tick_o
);
   typedef struct packed {
      logic [7:0] cnt;
      logic tick;
   } ubrg_div_s;
   ubrg_div_s s_q, s_d;

   // Count enabled ticks and pulse at the terminal value
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (en_i) begin
         if (s_q.cnt >= term_i) begin
            s_d.cnt = UBRG_RST_BYTE;
            s_d.tick = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;
endmodule

// ---- src/ubrg_pkg.sv ----
/*
 Package for the UART1 baud rate generator: APB register map, field
 positions, reset values, mode codes and fixed division counts.
 Assumes a single 40 MHz system clock domain.
*/
package ubrg_pkg;
   // Register byte offsets
   localparam logic [7:0] UBRG_OFS_CTRL = 8'h00;
   localparam logic [7:0] UBRG_OFS_RELOAD = 8'h04;
   localparam logic [7:0] UBRG_OFS_COUNTER = 8'h08;
   localparam logic [7:0] UBRG_OFS_STATUS = 8'h0C;
   // Control register field positions
   localparam int UBRG_CTL_RUN = 0;
   localparam int UBRG_CTL_BYPASS = 1;
   localparam int UBRG_CTL_DOUBLER = 2;
   localparam int UBRG_CTL_X3 = 3;
   localparam int UBRG_CTL_P0SEL = 4;
   localparam int UBRG_CTL_MODE_LO = 5;
   localparam int UBRG_CTL_TIMER = 8;
   localparam int UBRG_CTL_P0X3 = 9;
   localparam int UBRG_CTL_W = 10;
   // Reset values
   localparam logic [7:0] UBRG_RST_BYTE = 8'h00;
   localparam logic [9:0] UBRG_RST_CTRL = 10'h000;
   // Mode codes, zero through four
   localparam logic [2:0] UBRG_MODE0 = 3'h0;
   localparam logic [2:0] UBRG_MODE1 = 3'h1;
   localparam logic [2:0] UBRG_MODE2 = 3'h2;
   localparam logic [2:0] UBRG_MODE3 = 3'h3;
   localparam logic [2:0] UBRG_MODE4 = 3'h4;
   // Fixed division counts (terminal values)
   localparam logic [7:0] UBRG_DIV12 = 8'h0B;
   localparam logic [7:0] UBRG_DIV4 = 8'h03;
   localparam logic [7:0] UBRG_DIV32 = 8'h1F;
   localparam logic [7:0] UBRG_DIV64 = 8'h3F;
   localparam logic [7:0] UBRG_DIV96 = 8'h5F;
   localparam logic [7:0] UBRG_DIV192 = 8'hBF;
   localparam logic [3:0] UBRG_DIV16 = 4'hF;
   localparam logic [3:0] UBRG_DIV8 = 4'h7;
   localparam logic [7:0] UBRG_CNT_MAX = 8'hFF;
   localparam logic [31:0] UBRG_ZERO32 = 32'h0000_0000;
endpackage

// ---- src/ubrg_top.sv ----
/*
 Baud rate generator of the second serial port: 8-bit auto-reload counter,
 divide-by-two clock output, peripheral toggle source, port 0 time base
 selection and the fixed-rate shift and bit clocks of modes 0, 2 and 4.
 Assumes an APB master on the same 40 MHz clock and a serial engine that
 consumes one-cycle tick enables.
*/
// Overview of operation
// - an 8-bit up-counter plus a separate software-writable 8-bit reload register.
// - overflow reloads the counter and keeps counting; time base for modes 1, 3.
// - while stopped, writing the reload value also writes the counter.
// - while running, reload writes leave the counter alone.
// - counter writes change only the counter, never the reload value.
// - clock output toggles on each overflow, half the overflow rate.
// - overflow feeds other peripherals whenever the generator runs, engine busy or idle.
// - software may select the overflow as serial port 0 baud time base.
// - modes 1, 3 rate is 2^doubler/16 of clock/(12 or 1)/(256-reload).
// - mode 0 shift clock is system clock over 12, or over 4.
// - mode 2 rate is 2^doubler times system clock over 64 or 192.
// - five operating modes, zero through four.
// - no framing error detection and no address recognition here.
// - in modes 0 and 4 the bypass bit acts as the times-three control.
// - port plus generator can act as an 8-bit auto-reload timer.
// - this port runs independently of port 0, own mode and speed.
module ubrg_top
   import ubrg_pkg::*;
(
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic baud_overflow_pulse_o,
   output logic baud_clock_out_o,
   output logic periph_toggle_o,
   output logic port0_time_base_o,
   output logic bit_tick_o,
   output logic shift_tick_o,
   output logic timer_flag_o
);
   typedef struct packed {
      logic [7:0] baud_counter;
      logic [7:0] baud_reload_value;
      logic baud_gen_run;
      logic clock_div12_bypass;
      logic baud_doubler;
      logic mode_times_three;
      logic port0_sel;
      logic [2:0] mode;
      logic port1_timer_mode;
      logic port0_times_three;
      logic ovf;
      logic clk_out;
      logic toggle;
      logic p0_tb;
      logic [3:0] sub16;
      logic bit_tick;
      logic shift_tick;
      logic timer_flag;
      logic [3:0] pre12;
   } ubrg_s;
   ubrg_s s_q, s_d;

   logic wr_ctrl, wr_reload, wr_counter;
   logic sys_div12;
   logic fix_tick;
   logic [7:0] fix_term;
   logic [31:0] rd_ctrl, rd_reload, rd_counter, rd_status;

   // Wrap test used by the counting path
   function automatic logic ubrg_wraps(input logic [7:0] cnt);
      return cnt == UBRG_CNT_MAX;
   endfunction

   // Register bus slave
   ubrg_apb u_apb (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .rd_ctrl_i(rd_ctrl),
      .rd_reload_i(rd_reload),
      .rd_counter_i(rd_counter),
      .rd_status_i(rd_status),
      .wr_ctrl_o(wr_ctrl),
      .wr_reload_o(wr_reload),
      .wr_counter_o(wr_counter),
      .prdata_o(prdata_o),
      .pslverr_o(pslverr_o)
   );

   // Read-back images, upper bits zero
   always_comb begin
      rd_ctrl = UBRG_ZERO32;
      rd_ctrl[UBRG_CTL_RUN] = s_q.baud_gen_run;
      rd_ctrl[UBRG_CTL_BYPASS] = s_q.clock_div12_bypass;
      rd_ctrl[UBRG_CTL_DOUBLER] = s_q.baud_doubler;
      rd_ctrl[UBRG_CTL_X3] = s_q.mode_times_three;
      rd_ctrl[UBRG_CTL_P0SEL] = s_q.port0_sel;
      rd_ctrl[UBRG_CTL_MODE_LO +: 3] = s_q.mode;
      rd_ctrl[UBRG_CTL_TIMER] = s_q.port1_timer_mode;
      rd_ctrl[UBRG_CTL_P0X3] = s_q.port0_times_three;
      rd_reload = {24'h000000, s_q.baud_reload_value};
      rd_counter = {24'h000000, s_q.baud_counter};
      rd_status = {29'h00000000, s_q.timer_flag, s_q.clk_out, s_q.baud_gen_run};
   end

   // Fixed-rate divider term: modes 0/4 and mode 2
   always_comb begin
      unique case (s_q.mode)
         UBRG_MODE0, UBRG_MODE4: fix_term = s_q.clock_div12_bypass ? UBRG_DIV4 : UBRG_DIV12;
         UBRG_MODE2: begin
            if (s_q.mode_times_three) begin
               fix_term = s_q.baud_doubler ? UBRG_DIV96 : UBRG_DIV192;
            end else begin
               fix_term = s_q.baud_doubler ? UBRG_DIV32 : UBRG_DIV64;
            end
         end
         default: fix_term = UBRG_DIV12;
      endcase
   end

   // Shift/bit clock for fixed-rate modes, independent of the counter
   ubrg_divider u_fix (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .en_i(1'b1),
      .term_i(fix_term),
      .tick_o(fix_tick)
   );

   // Prescaler tick: system clock over twelve
   assign sys_div12 = (s_q.pre12 == UBRG_DIV12[3:0]);

   // Next-state logic of the generator
   always_comb begin
      logic adv;
      logic wrap;
      adv = 1'b0;
      wrap = 1'b0;
      s_d = s_q;
      s_d.pre12 = sys_div12 ? 4'h0 : s_q.pre12 + 4'h1;
      s_d.ovf = 1'b0;
      s_d.bit_tick = 1'b0;
      s_d.shift_tick = 1'b0;
      // Control register
      if (wr_ctrl) begin
         s_d.baud_gen_run = pwdata_i[UBRG_CTL_RUN];
         s_d.clock_div12_bypass = pwdata_i[UBRG_CTL_BYPASS];
         s_d.baud_doubler = pwdata_i[UBRG_CTL_DOUBLER];
         s_d.mode_times_three = pwdata_i[UBRG_CTL_X3];
         s_d.port0_sel = pwdata_i[UBRG_CTL_P0SEL];
         s_d.mode = (pwdata_i[UBRG_CTL_MODE_LO +: 3] > UBRG_MODE4) ? UBRG_MODE0
                    : pwdata_i[UBRG_CTL_MODE_LO +: 3];
         s_d.port1_timer_mode = pwdata_i[UBRG_CTL_TIMER];
         s_d.port0_times_three = pwdata_i[UBRG_CTL_P0X3];
      end
      // Counting, one step per selected tick
      adv = s_q.baud_gen_run && (s_q.clock_div12_bypass || sys_div12);
      wrap = adv && ubrg_wraps(s_q.baud_counter);
      if (adv) begin
         s_d.baud_counter = wrap ? s_q.baud_reload_value : s_q.baud_counter + 8'h01;
      end
      s_d.ovf = wrap;
      // Reload register write
      if (wr_reload) begin
         s_d.baud_reload_value = pwdata_i[7:0];
         if (!s_q.baud_gen_run) begin
            s_d.baud_counter = pwdata_i[7:0];
         end
      end
      // Direct counter write never touches the reload value
      if (wr_counter) begin
         s_d.baud_counter = pwdata_i[7:0];
      end
      // Derived clocks from overflow
      if (wrap) begin
         s_d.clk_out = !s_q.clk_out;
         s_d.toggle = !s_q.toggle;
         s_d.sub16 = s_q.sub16 + 4'h1;
         if (s_q.port1_timer_mode) begin
            s_d.timer_flag = 1'b1;
         end
         if ((s_q.baud_doubler && (s_q.sub16[2:0] == UBRG_DIV8[2:0]))
             || (s_q.sub16 == UBRG_DIV16)) begin
            s_d.bit_tick = (s_q.mode == UBRG_MODE1) || (s_q.mode == UBRG_MODE3);
         end
      end
      // Control write with the timer bit low clears the flag; a new overflow wins
      if (wr_ctrl && !pwdata_i[UBRG_CTL_TIMER] && !wrap) begin
         s_d.timer_flag = 1'b0;
      end
      s_d.p0_tb = s_q.port0_sel && wrap;
      // Fixed-rate modes; no frame error or address match logic exists here
      if ((s_q.mode == UBRG_MODE0) || (s_q.mode == UBRG_MODE4)) begin
         s_d.shift_tick = fix_tick;
      end else if (s_q.mode == UBRG_MODE2) begin
         s_d.bit_tick = fix_tick;
      end
   end

   // State register
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flops, pready tied high
   assign pready_o = 1'b1;
   assign baud_overflow_pulse_o = s_q.ovf;
   assign baud_clock_out_o = s_q.clk_out;
   assign periph_toggle_o = s_q.toggle;
   assign port0_time_base_o = s_q.p0_tb;
   assign bit_tick_o = s_q.bit_tick;
   assign shift_tick_o = s_q.shift_tick;
   assign timer_flag_o = s_q.timer_flag;
endmodule
